// ---- design/ldrw_pkg.sv ----
// shared constants and types for the display ram write path
package ldrw_pkg;
  localparam int NSEG = 40;              // segment columns
  localparam int NCOM = 4;               // common rows
  localparam int BYTE_W = 8;             // i2c data unit
  localparam int GROUPS = 5;             // eight-segment groups per row
  localparam int FIFO_DEPTH = 32;        // byte buffer depth
  // duty field codes as sent by the mode set command
  localparam logic [1:0] DUTY_STATIC = 2'h1;
  localparam logic [1:0] DUTY_HALF = 2'h2;
  localparam logic [1:0] DUTY_THIRD = 2'h3;
  localparam logic [1:0] DUTY_QUARTER = 2'h0;
  // pointer advance per byte, per duty
  localparam logic [5:0] STEP_STATIC = 6'h08;
  localparam logic [5:0] STEP_HALF = 6'h04;
  localparam logic [5:0] STEP_THIRD = 6'h03;
  localparam logic [5:0] STEP_QUARTER = 6'h02;
  localparam logic [5:0] PTR_LIMIT = 6'h28;   // 40, pointer wraps here
  // reset values
  localparam logic [5:0] PTR_RST = 6'h00;
  localparam logic [2:0] GRP_RST = 3'h0;
  localparam logic [1:0] ROW_RST = 2'h0;
  // buffered i2c item: address load or display byte
  typedef struct packed {
    logic is_addr;                       // 1: payload is pointer/row, 0: display byte
    logic [7:0] payload;
  } ldrw_entry_t;
  localparam int ENTRY_W = $bits(ldrw_entry_t);
endpackage

// ---- design/ldrw_fifo.sv ----
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ldrw_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  // refuse shapes the pointer logic cannot serve
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
      $error("ldrw_fifo: depth must be a power of two >= 2");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rp_q];

  // occupancy
  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + (AW+1)'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - (AW+1)'(1);
    end
  end

  // pointers, count and registered ready
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      in_ready <= 1'b0;
    end else begin
      if (push) wp_q <= wp_q + AW'(1);
      if (pop) rp_q <= rp_q + AW'(1);
      cnt_q <= cnt_d;
      in_ready <= (cnt_d != (AW+1)'(DEPTH));
    end
  end

  // storage
  always_ff @(posedge clk) begin
    if (push) mem[wp_q] <= in_data;
  end
endmodule // ldrw_fifo
`default_nettype wire

// ---- design/ldrw_top.sv ----
// display ram write mapping for a 40 x 4 lcd segment driver
`timescale 1ns/1ps
`default_nettype none
module ldrw_top #(
  parameter int DEPTH = ldrw_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // strap pins, asynchronous
  input wire logic i2c_sel_pin,
  input wire logic table_b_pin,
  input wire logic cascade_slave_pin,
  // duty from the mode set command
  input wire logic [1:0] duty,
  // i2c decoded items
  input wire logic item_valid,
  input wire ldrw_pkg::ldrw_entry_t item,
  output logic item_ready,
  // serial decoded words
  input wire logic word_valid,
  input wire logic [1:0] word_row,
  input wire logic [39:0] word_data,
  // display state
  output logic [3:0][39:0] dot_on_q,
  output logic com_ground_q
);
  localparam int NSEG = ldrw_pkg::NSEG;
  localparam int NCOM = ldrw_pkg::NCOM;

  initial begin
    if (DEPTH < 2) begin
      $error("ldrw_top: fifo depth too small");
    end
  end

  // two-stage synchronisers for strap pins
  logic [2:0] pin_m_q, pin_s_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_m_q <= 3'h0;
      pin_s_q <= 3'h0;
    end else begin
      pin_m_q <= {cascade_slave_pin, table_b_pin, i2c_sel_pin};
      pin_s_q <= pin_m_q;
    end
  end
  logic i2c_s, tb_s, slave_s;
  assign i2c_s = pin_s_q[0];
  assign tb_s = pin_s_q[1] && i2c_s;
  assign slave_s = pin_s_q[2];

  // byte buffer
  logic [ldrw_pkg::ENTRY_W-1:0] f_out;
  logic f_valid, f_pop, ser_wr;
  ldrw_pkg::ldrw_entry_t ent;
  ldrw_fifo #(.WIDTH(ldrw_pkg::ENTRY_W), .DEPTH(DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(item_valid),
    .in_data(item),
    .in_ready(item_ready),
    .out_valid(f_valid),
    .out_data(f_out),
    .out_ready(f_pop)
  );
  assign ent = ldrw_pkg::ldrw_entry_t'(f_out);

  // serial mode takes words; i2c mode drains the buffer
  assign ser_wr = word_valid && !i2c_s;
  assign f_pop = f_valid && i2c_s;

  logic byte_a, byte_b, load_a, load_b;
  assign byte_a = f_pop && !ent.is_addr && !tb_s;
  assign byte_b = f_pop && !ent.is_addr && tb_s;
  assign load_a = f_pop && ent.is_addr && !tb_s;
  assign load_b = f_pop && ent.is_addr && tb_s;

  // commons per duty and pointer step
  int ncom;
  logic [5:0] step;
  always_comb begin
    case (duty)
      ldrw_pkg::DUTY_STATIC: begin
        ncom = 1;
        step = ldrw_pkg::STEP_STATIC;
      end
      ldrw_pkg::DUTY_HALF: begin
        ncom = 2;
        step = ldrw_pkg::STEP_HALF;
      end
      ldrw_pkg::DUTY_THIRD: begin
        ncom = 3;
        step = ldrw_pkg::STEP_THIRD;
      end
      default: begin
        ncom = 4;
        step = ldrw_pkg::STEP_QUARTER;
      end
    endcase
  end

  // table A row and group walk
  logic [1:0] row_q;
  logic [2:0] grp_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      row_q <= ldrw_pkg::ROW_RST;
      grp_q <= ldrw_pkg::GRP_RST;
    end else if (load_a) begin
      row_q <= ent.payload[1:0];
      grp_q <= ldrw_pkg::GRP_RST;
    end else if (byte_a) begin
      grp_q <= (grp_q == 3'(ldrw_pkg::GROUPS - 1)) ? ldrw_pkg::GRP_RST
                                                  : grp_q + 3'h1;
    end
  end

  // table B pointer with auto advance
  logic [5:0] ptr_q, ptr_sum;
  assign ptr_sum = ptr_q + step;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ptr_q <= ldrw_pkg::PTR_RST;
    end else if (load_b) begin
      ptr_q <= ent.payload[5:0];
    end else if (byte_b) begin
      ptr_q <= (ptr_sum >= ldrw_pkg::PTR_LIMIT) ? ptr_sum - ldrw_pkg::PTR_LIMIT
                                                : ptr_sum;
    end
  end

  // per-cell write decode
  for (genvar c = 0; c < NCOM; c++) begin : g_com
    for (genvar s = 0; s < NSEG; s++) begin : g_seg
      logic we, wd;
      int ka, kb, bb;
      always_comb begin
        ka = s - (32 - 8 * int'(grp_q));
        kb = s - int'(ptr_q);
        bb = 7 - ncom * kb - c;
        we = 1'b0;
        wd = 1'b0;
        if (ser_wr && word_row == 2'(c)) begin
          we = 1'b1;
          wd = word_data[NSEG-1-s];
        end else if (byte_a && row_q == 2'(c) && ka >= 0 && ka < 8) begin
          we = 1'b1;
          wd = ent.payload[ka[2:0]];
        end else if (byte_b && kb >= 0 && c < ncom && bb >= 0 && bb < 8) begin
          we = 1'b1;
          wd = ent.payload[bb[2:0]];
        end
      end
      // dot cell: one lights, zero dark
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          dot_on_q[c][s] <= 1'b0;
        end else if (we) begin
          dot_on_q[c][s] <= wd;
        end
      end
    end
  end

  // slave chips ground their commons
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      com_ground_q <= 1'b0;
    end else begin
      com_ground_q <= slave_s;
    end
  end

  // checks
  property p_slave_gnd;
    @(posedge clk) disable iff (!rst_n)
    slave_s |=> com_ground_q;
  endproperty
  a_slave_gnd: assert property (p_slave_gnd) else $error("slave commons not grounded");

  property p_ptr_step;
    @(posedge clk) disable iff (!rst_n)
    byte_b && duty == ldrw_pkg::DUTY_THIRD && ptr_q < 6'h20 |=> ptr_q == $past(ptr_q) + 6'h03;
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer advance wrong");

  property p_serial_ends;
    @(posedge clk) disable iff (!rst_n)
    ser_wr |=> dot_on_q[$past(word_row)][0] == $past(word_data[39])
           && dot_on_q[$past(word_row)][39] == $past(word_data[0]);
  endproperty
  a_serial_ends: assert property (p_serial_ends) else $error("serial bit order wrong");

  property p_group_order;
    @(posedge clk) disable iff (!rst_n)
    byte_a && grp_q == 3'h0 |=> grp_q == 3'h1 ##0 dot_on_q[row_q][32] == $past(ent.payload[0]);
  endproperty
  a_group_order: assert property (p_group_order) else $error("table A placement wrong");

  property p_row_load;
    @(posedge clk) disable iff (!rst_n)
    load_a |=> row_q == $past(ent.payload[1:0]) && grp_q == 3'h0;
  endproperty
  a_row_load: assert property (p_row_load) else $error("row load wrong");

  property p_static_msb;
    @(posedge clk) disable iff (!rst_n)
    byte_b && duty == ldrw_pkg::DUTY_STATIC && ptr_q < 6'h28
      |=> dot_on_q[0][$past(ptr_q)] == $past(ent.payload[7]);
  endproperty
  a_static_msb: assert property (p_static_msb) else $error("static msb misplaced");

  property p_third_keep;
    @(posedge clk) disable iff (!rst_n)
    byte_b && duty == ldrw_pkg::DUTY_THIRD && ptr_q < 6'h26 && !ser_wr
      |=> dot_on_q[2][$past(ptr_q) + 6'h02] == $past(dot_on_q[2][ptr_q + 6'h02]);
  endproperty
  a_third_keep: assert property (p_third_keep) else $error("third com3 overwritten");

  property p_quarter_lsb;
    @(posedge clk) disable iff (!rst_n)
    byte_b && duty == ldrw_pkg::DUTY_QUARTER && ptr_q < 6'h27
      |=> dot_on_q[3][$past(ptr_q) + 6'h01] == $past(ent.payload[0]);
  endproperty
  a_quarter_lsb: assert property (p_quarter_lsb) else $error("quarter lsb misplaced");
endmodule // ldrw_top
`default_nettype wire

// ---- verification/ldrw_host.sv ----
// host side model offering queued i2c items over valid/ready
`timescale 1ns/1ps
`default_nettype none
module ldrw_host (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // item bus
  input wire logic item_ready,
  output logic item_valid,
  output ldrw_pkg::ldrw_entry_t item
);
  ldrw_pkg::ldrw_entry_t q[$];
  // hold an offer until taken; an idle bus inverts its payload every cycle
  always @(posedge clk) begin
    if (!rst_n) begin
      item_valid <= 1'b0;
      item <= '0;
    end else if (!item_valid || item_ready) begin
      item_valid <= q.size() > 0;
      item <= (q.size() > 0) ? q.pop_front() : ~item;
    end
  end
endmodule // ldrw_host
`default_nettype wire

// ---- verification/ldrw_top_test.sv ----
// self-checking bench for the display ram write path
`timescale 1ns/1ps
`default_nettype none
module ldrw_top_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic i2c_sel_pin = 1'b0;
  logic table_b_pin = 1'b0;
  logic cascade_slave_pin = 1'b0;
  logic [1:0] duty = 2'h1;
  logic item_ready;
  logic item_valid;
  ldrw_pkg::ldrw_entry_t item;
  logic word_valid = 1'b0;
  logic [1:0] word_row = 2'h0;
  logic [39:0] word_data = 40'h0;
  logic [3:0][39:0] dot_on_q;
  logic [3:0][39:0] model;
  logic com_ground_q;
  int miscompares = 0;
  int checked = 0;
  // clock, 25 ns period
  always #12.5 clk = ~clk;
  ldrw_top u_ldrw_top (.clk(clk), .rst_n(rst_n), .i2c_sel_pin(i2c_sel_pin),
    .table_b_pin(table_b_pin), .cascade_slave_pin(cascade_slave_pin), .duty(duty),
    .item_valid(item_valid), .item(item), .item_ready(item_ready),
    .word_valid(word_valid), .word_row(word_row), .word_data(word_data),
    .dot_on_q(dot_on_q), .com_ground_q(com_ground_q));
  ldrw_host u_ldrw_host (.clk(clk), .rst_n(rst_n), .item_ready(item_ready),
    .item_valid(item_valid), .item(item));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string what, input logic [159:0] seen, input logic [159:0] want);
    checked++;
    if (seen !== want) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic summarize;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic put(input logic a, input logic [7:0] v);
    u_ldrw_host.q.push_back('{is_addr: a, payload: v});
  endtask
  // bounded wait until the host has handed everything over
  task automatic drain;
    int i;
    for (i = 0; i < 200 && (u_ldrw_host.q.size() > 0 || item_valid); i++) cyc(1);
    chk("drain timeout", 160'(i == 200), 160'h0);
    if (i == 200) summarize();
    cyc(40);
  endtask
  task automatic t_serial;
    word_valid <= 1'b1;
    word_row <= 2'h2;
    word_data <= 40'h80_0000_0003;
    @(posedge clk);
    word_valid <= 1'b0;
    cyc(3);
    model[2] = 40'hC0_0000_0001;
    chk("serial row", dot_on_q, model);
    $display("test serial done");
  endtask
  // fill the fifo in serial mode, then drain it in table a mode
  task automatic t_table_a;
    int k;
    put(1'b1, 8'h01);
    for (k = 0; k <= 32; k++) put(1'b0, 8'(k * 7 + 3));
    cyc(50);
    chk("fifo full", 160'(item_ready), 160'h0);
    chk("items left", 160'(u_ldrw_host.q.size()), 160'h1);
    i2c_sel_pin <= 1'b1;
    drain();
    for (k = 0; k <= 32; k++) model[1][32 - 8 * (k % 5) +: 8] = 8'(k * 7 + 3);
    chk("table a", dot_on_q, model);
    $display("test table_a done");
  endtask
  task automatic t_table_b(input logic [1:0] d, input int n, input int p, input int cnt);
    int k;
    int s;
    int j;
    logic [7:0] v;
    duty <= d;
    put(1'b1, 8'(p));
    for (k = 0; k < cnt; k++) begin
      v = 8'hA5 ^ 8'(k);
      put(1'b0, v);
      for (s = 0; s * n < 8; s++) begin
        for (j = 0; j < n; j++) begin
          if (7 - n * s - j >= 0 && p + s < 40) model[j][p + s] = v[7 - n * s - j];
        end
      end
      p = (p + ((n == 3) ? 3 : 8 / n)) % 40;
    end
    drain();
    chk("table b", dot_on_q, model);
    $display("test table_b duty %0d done", n);
  endtask
  task automatic t_slave;
    cascade_slave_pin <= 1'b1;
    word_valid <= 1'b1;
    word_row <= 2'h0;
    word_data <= 40'hFF_FFFF_FFFF;
    @(posedge clk);
    word_valid <= 1'b0;
    cyc(4);
    chk("slave commons", 160'(com_ground_q), 160'h1);
    chk("serial ignored", dot_on_q, model);
    cascade_slave_pin <= 1'b0;
    cyc(4);
    chk("master commons", 160'(com_ground_q), 160'h0);
    $display("test slave done");
  endtask
  // main sequence
  initial begin
    model = '0;
    cyc(6);
    rst_n <= 1'b1;
    cyc(3);
    chk("reset dots", dot_on_q, 160'h0);
    t_serial();
    t_table_a();
    table_b_pin <= 1'b1;
    cyc(4);
    t_table_b(ldrw_pkg::DUTY_STATIC, 1, 36, 2);
    t_table_b(ldrw_pkg::DUTY_HALF, 2, 0, 3);
    t_table_b(ldrw_pkg::DUTY_QUARTER, 4, 38, 2);
    t_table_b(ldrw_pkg::DUTY_THIRD, 3, 20, 2);
    t_table_b(ldrw_pkg::DUTY_THIRD, 3, 25, 1);
    t_slave();
    summarize();
  end
endmodule // ldrw_top_test
`default_nettype wire
